// ===== pkg/bkgpio_pkg.sv
package bkgpio_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_DIRECTION   = 8'h00;
    localparam logic [7:0]  OFS_INPUT_LEVEL = 8'h04;
    localparam logic [7:0]  OFS_OUTPUT_LVL  = 8'h08;
    localparam logic [7:0]  OFS_POD         = 8'h0C;
    localparam logic [7:0]  OFS_FUNC_SEL    = 8'h10;
    localparam logic [7:0]  OFS_PULL_UP     = 8'h14;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          NUM_PINS        = 4;
    localparam int          NUM_POD         = 2;
    localparam int          FUNC_W          = 6;
    localparam int          PIN_OSC_IN      = 3;
    localparam int          PIN_OSC_OUT     = 2;
    localparam int          PIN_WAKE        = 1;
    localparam int          PIN_REGULATOR   = 0;
    localparam int          OSC_SEL_LSB     = 4;
    localparam logic [3:0]  DIR_RESET       = 4'h0;
    localparam logic [3:0]  OUT_RESET       = 4'hF;
    localparam logic [1:0]  POD_RESET       = 2'h3;
    localparam logic [5:0]  FUNC_RESET      = 6'h1C;
    localparam logic [3:0]  PULL_RESET      = 4'h0;

    // Oscillator pin function field codes
    localparam logic [1:0]  OSC_SEL_CRYSTAL = 2'h1;
    localparam logic [1:0]  OSC_SEL_EXTCLK  = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          SYNC_STAGES     = 2;

endpackage : bkgpio_pkg

// ===== design/level_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Two-flop synchroniser for asynchronous pin levels
// ------------------------------------------------------------
module level_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : level_sync

`default_nettype wire

// ===== design/pin_driver.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Output stage of one backup-domain pin
// ------------------------------------------------------------
module pin_driver #(
    parameter bit HAS_POD  = 1'b0,
    parameter bit NO_DRIVE = 1'b0
) (
    input  wire logic periph_mode,
    input  wire logic dir,
    input  wire logic out_val,
    input  wire logic periph_out,
    input  wire logic periph_oe,
    input  wire logic pod,
    input  wire logic pull_set,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pull_en
);

    logic raw_oe;
    logic pod_on;

    // Peripheral owns the pin, else port data under direction bit
    assign pin_out = periph_mode ? periph_out : out_val;        // [RULE8] [RULE12]
    assign raw_oe  = periph_mode ? periph_oe : dir;             // [RULE2] [RULE9] [RULE16]
    assign pod_on  = HAS_POD && pod;

    // A high level under pseudo-open-drain floats the pin instead
    assign pin_oe  = !NO_DRIVE && raw_oe && !(pod_on && pin_out); // [RULE11] [RULE13]

    // Pull-up only on an undriven pin, and never under pseudo-open-drain
    assign pull_en = pull_set && !pin_oe && !pod_on;            // [RULE13]

endmodule : pin_driver

`default_nettype wire

// ===== design/backup_domain_gpio_port.sv
// Function
// RULE1 - A set direction bit makes its pin an output and a clear one an input, bit 3 osc-in down to bit 0 regulator.
// RULE2 - A pin given to a peripheral function ignores its direction bit.
// RULE3 - Direction bits reset to zero and read back as stored.
// RULE4 - Bits 7 to 4 of direction, input and output registers read zero and software writes zero there.
// RULE5 - Each input bit shows the real pin level whatever the function, direction and output settings.
// RULE6 - Oscillator pins in their special function read zero as input data.
// RULE7 - Writing the input register changes nothing and its reset value is undefined.
// RULE8 - A port output pin is driven low for a zero output bit and high for a one.
// RULE9 - An input or peripheral pin stores its output bit without it reaching the pin.
// RULE10 - Output bits reset to one and read back as stored.
// RULE11 - On input-only variants the oscillator pins are never driven and their output bits do nothing.
// RULE12 - With pseudo-open-drain off a high from port or peripheral drives the pin high.
// RULE13 - With pseudo-open-drain on a high leaves the pin floating and its pull-up off.
// RULE14 - The pseudo-open-drain register has bits 1 and 0 resetting to one, the rest reading zero.
// RULE15 - Oscillator function code 01 gives both oscillator pins to the crystal, and is the reset value.
// RULE16 - A function bit of zero gives its pin to the port and one to the peripheral.
// RULE17 - Pin levels pass two flip-flops before they are read back.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module backup_domain_gpio_port
    import bkgpio_pkg::*;
#(
    parameter bit OSC_INPUT_ONLY = 1'b0
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_PINS-1:0] periph_out,
    input  wire logic [NUM_PINS-1:0] periph_oe,
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe,
    output logic      [NUM_PINS-1:0] pin_pullup_en
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_direction_q;
    logic [NUM_PINS-1:0] pin_output_level_q;
    logic [NUM_POD-1:0]  pin_pseudo_open_drain_q;
    logic [FUNC_W-1:0]   pin_function_select_q;
    logic [NUM_PINS-1:0] pull_up_setting_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic                wr_en;
    logic                setup;
    logic [ADDR_W-1:0]   word_addr;
    logic                addr_hit;
    logic [31:0]         rd_mux;

    assign setup     = psel && !penable;
    assign wr_en     = psel && penable && pwrite;
    assign word_addr = paddr[ADDR_W-1:0];

    // Only aligned words inside the map are claimed
    assign addr_hit  = (paddr[31:ADDR_W] == '0) && (paddr[1:0] == 2'h0) &&
                       ((word_addr == OFS_DIRECTION)   ||
                        (word_addr == OFS_INPUT_LEVEL) ||
                        (word_addr == OFS_OUTPUT_LVL)  ||
                        (word_addr == OFS_POD)         ||
                        (word_addr == OFS_FUNC_SEL)    ||
                        (word_addr == OFS_PULL_UP));

    // ------------------------------------------------------------
    // Pin function decode
    // ------------------------------------------------------------
    logic [1:0]          osc_sel;
    logic                osc_crystal;
    logic                osc_extclk;
    logic [NUM_PINS-1:0] periph_mode;
    logic [NUM_PINS-1:0] input_block;

    assign osc_sel     = pin_function_select_q[OSC_SEL_LSB+1:OSC_SEL_LSB];
    assign osc_crystal = (osc_sel == OSC_SEL_CRYSTAL);                     // [RULE15]
    assign osc_extclk  = (osc_sel == OSC_SEL_EXTCLK)
                         && pin_function_select_q[PIN_OSC_IN];

    // Crystal mode takes both oscillator pins whatever their own bits say
    always_comb begin
        periph_mode = pin_function_select_q[NUM_PINS-1:0];                 // [RULE16]
        periph_mode[PIN_OSC_IN]  = periph_mode[PIN_OSC_IN]  || osc_crystal; // [RULE15]
        periph_mode[PIN_OSC_OUT] = periph_mode[PIN_OSC_OUT] || osc_crystal; // [RULE15]
    end

    // Special oscillator use cuts the digital input path
    always_comb begin
        input_block = '0;
        input_block[PIN_OSC_IN]  = osc_crystal || osc_extclk;               // [RULE6]
        input_block[PIN_OSC_OUT] = osc_crystal;                             // [RULE6]
    end

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_sync;
    logic [NUM_PINS-1:0] pin_input_level;

    // Pin levels are asynchronous to pclk
    level_sync #(
        .WIDTH    (NUM_PINS)
    ) u_level_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );                                                                      // [RULE17]

    // Real pin level unless input_block cuts it, so unblocked driven pins read back what they drive
    assign pin_input_level = pin_sync & ~input_block;                       // [RULE5] [RULE6]

    // ------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            localparam bit IS_OSC = (i == PIN_OSC_IN) || (i == PIN_OSC_OUT);
            pin_driver #(
                .HAS_POD     (!IS_OSC),
                .NO_DRIVE    (IS_OSC && OSC_INPUT_ONLY)
            ) u_pin_driver (
                .periph_mode (periph_mode[i]),
                .dir         (pin_direction_q[i]),
                .out_val     (pin_output_level_q[i]),
                .periph_out  (periph_out[i]),
                .periph_oe   (periph_oe[i]),
                .pod         (IS_OSC ? 1'b0 : pin_pseudo_open_drain_q[i % NUM_POD]),
                .pull_set    (pull_up_setting_q[i]),
                .pin_out     (pin_out[i]),
                .pin_oe      (pin_oe[i]),
                .pull_en     (pin_pullup_en[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------

    // Direction bits; only the low byte lane carries fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_q <= DIR_RESET;                                   // [RULE3]
        end else if (wr_en && pstrb[0] && (word_addr == OFS_DIRECTION) && addr_hit) begin
            pin_direction_q <= pwdata[NUM_PINS-1:0];                         // [RULE1]
        end
    end

    // Output data is kept even while the pin ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_output_level_q <= OUT_RESET;                                // [RULE10]
        end else if (wr_en && pstrb[0] && (word_addr == OFS_OUTPUT_LVL) && addr_hit) begin
            pin_output_level_q <= pwdata[NUM_PINS-1:0];                      // [RULE9]
        end
    end

    // Pseudo-open-drain holds two bits only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pseudo_open_drain_q <= POD_RESET;                           // [RULE14]
        end else if (wr_en && pstrb[0] && (word_addr == OFS_POD) && addr_hit) begin
            pin_pseudo_open_drain_q <= pwdata[NUM_POD-1:0];                  // [RULE14]
        end
    end

    // Function select and pull-up setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_function_select_q <= FUNC_RESET;                            // [RULE15]
            pull_up_setting_q     <= PULL_RESET;
        end else if (wr_en && pstrb[0] && addr_hit) begin
            if (word_addr == OFS_FUNC_SEL) begin
                pin_function_select_q <= pwdata[FUNC_W-1:0];
            end
            if (word_addr == OFS_PULL_UP) begin
                pull_up_setting_q <= pwdata[NUM_PINS-1:0];
            end
        end
    end

    // The input register has no write path at all                          [RULE7]

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Unused upper bits read zero on every register
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (word_addr)
            OFS_DIRECTION:   rd_mux[NUM_PINS-1:0] = pin_direction_q;         // [RULE3] [RULE4]
            OFS_INPUT_LEVEL: rd_mux[NUM_PINS-1:0] = pin_input_level;         // [RULE4] [RULE5]
            OFS_OUTPUT_LVL:  rd_mux[NUM_PINS-1:0] = pin_output_level_q;      // [RULE4] [RULE10]
            OFS_POD:         rd_mux[NUM_POD-1:0]  = pin_pseudo_open_drain_q; // [RULE14]
            OFS_FUNC_SEL:    rd_mux[FUNC_W-1:0]   = pin_function_select_q;
            OFS_PULL_UP:     rd_mux[NUM_PINS-1:0] = pull_up_setting_q;
            default:         rd_mux = 32'h0000_0000;
        endcase
        if (!addr_hit) begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Answer is captured in the setup cycle and stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !addr_hit;
        end
    end

    // Zero wait states, so the access phase is always one cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic access_rd;
    assign access_rd = psel && penable && !pwrite;

    AST_DIR_WRITE: assert property ( // [RULE1]
        wr_en && pstrb[0] && addr_hit && word_addr == OFS_DIRECTION
        |=> pin_direction_q == $past(pwdata[NUM_PINS-1:0]))
        else $error("direction register did not take written value");

    AST_PERIPH_IGNORES_DIR: assert property ( // [RULE2]
        periph_mode[PIN_REGULATOR] && !pin_pseudo_open_drain_q[PIN_REGULATOR]
        |-> pin_oe[PIN_REGULATOR] == periph_oe[PIN_REGULATOR])
        else $error("peripheral pin enable not taken from peripheral");

    AST_RSVD_READ_ZERO: assert property ( // [RULE4]
        access_rd && word_addr != OFS_FUNC_SEL |-> prdata[31:NUM_PINS] == '0)
        else $error("upper read data bits not zero");

    AST_LEVEL_TRACKS_PIN: assert property ( // [RULE5]
        $stable(pin_in[PIN_WAKE]) [*3]
        |-> pin_input_level[PIN_WAKE] == pin_in[PIN_WAKE])
        else $error("wake level does not follow stable pin");

    AST_OSC_BLOCKED: assert property ( // [RULE6]
        osc_crystal |-> pin_input_level[PIN_OSC_IN:PIN_OSC_OUT] == 2'h0)
        else $error("oscillator input path not blocked");

    AST_INPUT_WRITE_NO_EFFECT: assert property ( // [RULE7]
        wr_en && word_addr == OFS_INPUT_LEVEL
        |=> $stable(pin_direction_q) && $stable(pin_output_level_q)
            && $stable(pin_pseudo_open_drain_q) && $stable(pin_function_select_q))
        else $error("write to input register changed state");

    AST_GPIO_DRIVE: assert property ( // [RULE8]
        !periph_mode[PIN_WAKE] && pin_direction_q[PIN_WAKE]
        && !pin_pseudo_open_drain_q[PIN_WAKE]
        |-> pin_oe[PIN_WAKE] && pin_out[PIN_WAKE] == pin_output_level_q[PIN_WAKE])
        else $error("port output pin not driven with its data bit");

    AST_INPUT_NOT_DRIVEN: assert property ( // [RULE9]
        !periph_mode[PIN_WAKE] && !pin_direction_q[PIN_WAKE] |-> !pin_oe[PIN_WAKE])
        else $error("input pin driven");

    AST_OSC_INPUT_ONLY: assert property ( // [RULE11]
        OSC_INPUT_ONLY |-> pin_oe[PIN_OSC_IN:PIN_OSC_OUT] == 2'h0)
        else $error("input-only oscillator pin driven");

    AST_POD_FLOATS_HIGH: assert property ( // [RULE13]
        pin_pseudo_open_drain_q[PIN_REGULATOR] && pin_out[PIN_REGULATOR]
        |-> !pin_oe[PIN_REGULATOR] && !pin_pullup_en[PIN_REGULATOR])
        else $error("pseudo-open-drain high not floating");

    AST_POD_READBACK: assert property ( // [RULE14]
        setup && !pwrite && addr_hit && word_addr == OFS_POD
        |=> prdata == {30'h0, $past(pin_pseudo_open_drain_q)})
        else $error("pseudo-open-drain read value wrong");

endmodule : backup_domain_gpio_port

`default_nettype wire

// ===== bench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Board side of the four pins
// ----------------------------------------
module pin_partner
    import bkgpio_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] pin_pullup_en,
    input  wire logic [NUM_PINS-1:0] ext_oe,
    input  wire logic [NUM_PINS-1:0] ext_val,
    output logic      [NUM_PINS-1:0] pin_in
);
    logic [NUM_PINS-1:0] last_q;

    // Device drive wins, then the board driver, then the pull-up;
    // a floating pin toggles so a stale level never looks driven
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_oe[i])
                pin_in[i] = ext_val[i];
            else if (pin_pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last_q[i];
        end
    end

    // History of the resolved level
    always_ff @(posedge pclk) begin
        last_q <= pin_in;
    end
endmodule : pin_partner

`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import bkgpio_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb, periph_out, periph_oe, pin_in, pin_out, pin_oe, pin_pullup_en;
    logic [3:0]  ext_oe, ext_val, dir, out, pull, po, poe, ev, eoe, elvl, blk, strb, oe_io;
    logic [5:0]  fsel;
    logic [1:0]  pod;
    int          err_total, total_checks;

    // ----------------------------------------
    // Clock, design and board
    // ----------------------------------------
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    backup_domain_gpio_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_out(periph_out), .periph_oe(periph_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));

    // Input-only oscillator variant on the same bus; only its drive enables are judged
    backup_domain_gpio_port #(.OSC_INPUT_ONLY(1'b1)) dut_input_only (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(), .pready(), .pslverr(), .periph_out(periph_out), .periph_oe(periph_oe),
        .pin_in(pin_in), .pin_out(), .pin_oe(oe_io), .pin_pullup_en());

    pin_partner board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));

    // ----------------------------------------
    // Checks, bus cycles and expectations
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t pins got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // One transfer; ends with an idle cycle so psel is never set twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h000000, a};
        pwdata  <= d;
        pstrb   <= w ? strb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("[FAIL] %0t no ready from slave", $time);
            results();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
        apb(1'b0, a, 32'h00000000);
        chk_reg(rd, exp);
        chk_reg({31'h00000000, er}, {31'h00000000, err_exp});
    endtask : rd_expect

    // Drive and level each pin should show, given the settings
    function automatic void expect_pins(input logic [5:0] f, input logic [3:0] d, input logic [3:0] o,
                                        input logic [1:0] p, output logic [3:0] oe, output logic [3:0] lvl);
        logic periph;
        logic [3:0] p4;
        p4 = {2'b00, p};
        for (int i = 0; i < 4; i++) begin
            periph = f[i] || (i >= 2 && f[5:4] == OSC_SEL_CRYSTAL);
            lvl[i] = periph ? po[i] : o[i];
            oe[i]  = periph ? poe[i] : d[i];
            if (p4[i] && lvl[i])
                oe[i] = 1'b0;
        end
    endfunction : expect_pins

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        strb = 4'hF;
        {periph_out, periph_oe, ext_val} = 12'h000;
        ext_oe = 4'hF;
        err_total = 0;
        total_checks = 0;
        void'($urandom(30));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        ext_val <= 4'hF;
        @(posedge pclk);
        rd_expect(OFS_DIRECTION, 32'h00000000, 1'b0);
        rd_expect(OFS_OUTPUT_LVL, 32'h0000000F, 1'b0);
        rd_expect(OFS_POD, 32'h00000003, 1'b0);
        rd_expect(OFS_FUNC_SEL, {26'h0000000, FUNC_RESET}, 1'b0);
        chk_pin(pin_oe, 4'h0);
        rd_expect(OFS_INPUT_LEVEL, 32'h00000003, 1'b0);
        $display("test reset done");
        // Reserved bits are written as zero and read zero; the input register and a
        // write without the low byte lane both leave state alone
        apb(1'b1, OFS_DIRECTION, 32'h0000000C);
        apb(1'b1, OFS_OUTPUT_LVL, 32'h00000005);
        apb(1'b1, OFS_POD, 32'h00000002);
        apb(1'b1, OFS_INPUT_LEVEL, 32'h0000000F);
        strb = 4'hE;
        apb(1'b1, OFS_OUTPUT_LVL, 32'h0000000A);
        strb = 4'hF;
        chk_pin(pin_oe, 4'h0);
        rd_expect(OFS_DIRECTION, 32'h0000000C, 1'b0);
        rd_expect(OFS_OUTPUT_LVL, 32'h00000005, 1'b0);
        rd_expect(OFS_POD, 32'h00000002, 1'b0);
        rd_expect(OFS_INPUT_LEVEL, 32'h00000003, 1'b0);
        rd_expect(8'h18, 32'h00000000, 1'b1);
        rd_expect(8'h01, 32'h00000000, 1'b1);
        $display("test reserved done");
        // Random settings over all four oscillator codes, pins judged against the model
        for (int k = 0; k < 60; k++) begin
            fsel = 6'($urandom);
            {dir, out, pod, pull} = 14'($urandom);
            {po, poe, ev} = 12'($urandom);
            if (k < 4) begin
                {fsel, dir, out, pod} = {6'h00, 4'hF, 4'hF, 2'(k)};
            end
            periph_out <= po;
            periph_oe  <= poe;
            ext_val    <= ev;
            apb(1'b1, OFS_FUNC_SEL, {26'h0000000, fsel});
            apb(1'b1, OFS_DIRECTION, {28'h0000000, dir});
            apb(1'b1, OFS_OUTPUT_LVL, {28'h0000000, out});
            apb(1'b1, OFS_POD, {30'h00000000, pod});
            apb(1'b1, OFS_PULL_UP, {28'h0000000, pull});
            expect_pins(fsel, dir, out, pod, eoe, elvl);
            blk = (fsel[5:4] == OSC_SEL_CRYSTAL) ? 4'hC : (fsel[5:4] == OSC_SEL_EXTCLK && fsel[3]) ? 4'h8 : 4'h0;
            @(negedge pclk);
            chk_pin(oe_io, eoe & 4'h3);
            chk_pin(pin_oe, eoe);
            chk_pin(pin_out & eoe, elvl & eoe);
            chk_pin(pin_pullup_en, pull & ~eoe & {2'b11, ~pod});
            @(posedge pclk);
            if (blk != 4'h0)
                rd_expect(OFS_INPUT_LEVEL, {28'h0, ((eoe & elvl) | (~eoe & ev)) & ~blk}, 1'b0);
            else
                rd_expect(OFS_INPUT_LEVEL, {28'h0, (eoe & elvl) | (~eoe & ev)}, 1'b0);
            rd_expect(OFS_OUTPUT_LVL, {28'h0000000, out}, 1'b0);
        end
        $display("test random done");
        results();
    end
endmodule : testbench

`default_nettype wire
